// ==== rtl/twr_pkg.sv ====
package twr_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NCH      = 17;   // channel 0 plus channels 1..16
    localparam int NRAM_CH  = 16;   // only channels 1..16 own a template ram
    localparam int NSAMP    = 20;
    localparam int RAM_WORDS = NRAM_CH * NSAMP;

    // ------------------------------------------------------------
    // register map (word indices; byte address is four times)
    // ------------------------------------------------------------
    localparam logic [10:0] OFS_SCALE     = 11'h007;
    localparam logic [10:0] OFS_CTRL      = 11'h008;
    localparam logic [10:0] OFS_DATA      = 11'h009;
    localparam logic [10:0] CH_STRIDE     = 11'h040;
    localparam logic [10:0] OFS_CH0_SCALE = 11'h7C7;
    localparam logic [10:0] OFS_CH0_CTRL  = 11'h7C8;
    localparam logic [5:0]  OFS_LOW_MASK  = 6'h3F;

    // ------------------------------------------------------------
    // reset values and fields
    // ------------------------------------------------------------
    localparam logic [5:0] SCALE_RST    = 6'h36;
    localparam logic [6:0] CTRL_RST     = 7'h00;
    localparam logic [6:0] DATA_RST     = 7'h00;
    localparam logic [5:0] SCALE_NOM_T1 = 6'h36;
    localparam logic [5:0] SCALE_NOM_E1 = 6'h21;
    localparam int CTRL_EN_BIT   = 6;
    localparam int CTRL_DIR_BIT  = 5;
    localparam int PULS_USER_BIT = 3;
    localparam logic [4:0] SAMP_LAST = 5'h13;
    localparam logic [8:0] NSAMP_W9  = 9'h014;

    // ------------------------------------------------------------
    // amplitude deviation in percent
    // ------------------------------------------------------------
    localparam int STEP_T1    = 2;
    localparam int STEP_E1    = 3;
    localparam int PCT_MAX_T1 = 20;
    localparam int PCT_MAX_E1 = 100;
    localparam int PCT_MIN    = -100;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum {REG_NONE, REG_SCALE, REG_CTRL, REG_DATA} twr_reg_e;
    typedef enum {BUS_IDLE, BUS_ACK} twr_bus_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [10:0] address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } twr_avmm_req_s;

    typedef struct packed {
        twr_reg_e    kind;
        logic [4:0]  ch;
    } twr_dec_s;

endpackage

// ==== rtl/twr_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - T1/J1: nominal scale 110110, 2 percent per step, range +20 to -100.
// - E1: nominal scale 100001, 3 percent per step, range +100 to -100.
// - ram access fields act only while template selector top bit is 1.
// - control bit 6 enables template ram access, reset disabled.
// - control bit 5 picks direction: 0 write ram, 1 read ram.
// - sample index 0..18 direct, codes 19..31 all address sample 19.
// - data register bits 6..0 hold the sample for the indexed location.
// - data register holds its value until new sample data is written or a control write launches a ram read.
// - scale registers at 0x007 plus 0x40 per channel, channel 0 at 0x7C7.
// - data register only for channels 1..16, 0x009 through 0x3C9.
// - selector codes 1xxx choose the user template in sample ram.
module twr_regs
    import twr_pkg::*;
(
    // clock and reset
    input  wire  logic                          mclk_i,
    input  wire  logic                          rstn_i,
    // avalon-mm slave
    input  wire  twr_avmm_req_s                 avm_req_i,
    output logic [31:0]                         avm_readdata_o,
    output logic                                avm_waitrequest_o,
    // per-channel configuration from neighbouring logic
    input  wire  logic [NCH-1:0][3:0]           pulse_template_select_i,
    input  wire  logic [NCH-1:0]                e1_mode_i,
    // template readout for the waveform generator
    input  wire  logic [3:0]                    tpl_rd_ch_i,
    input  wire  logic [4:0]                    tpl_rd_idx_i,
    output logic [6:0]                          tpl_rd_data_o,
    // amplitude outputs
    output logic [NCH-1:0][5:0]                 amplitude_factor_o,
    output logic [NCH-1:0][7:0]                 amplitude_pct_o
);

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    function automatic twr_dec_s decode(input logic [10:0] a);
        twr_dec_s d;
        d.kind = REG_NONE;
        d.ch   = 5'h00;
        if (a == OFS_CH0_SCALE) begin
            d.kind = REG_SCALE;
        end else if (a == OFS_CH0_CTRL) begin
            d.kind = REG_CTRL;
        end else if (!a[10]) begin
            d.ch = {1'b0, a[9:6]} + 5'h01;
            if ((a & {5'h00, OFS_LOW_MASK}) == OFS_SCALE) begin
                d.kind = REG_SCALE;
            end else if ((a & {5'h00, OFS_LOW_MASK}) == OFS_CTRL) begin
                d.kind = REG_CTRL;
            end else if ((a & {5'h00, OFS_LOW_MASK}) == OFS_DATA) begin
                d.kind = REG_DATA;
            end
        end
        return d;
    endfunction

    function automatic logic [8:0] ram_index(input logic [3:0] rch, input logic [4:0] samp);
        logic [4:0] s;
        s = (samp > SAMP_LAST) ? SAMP_LAST : samp;
        return ({5'h00, rch} * NSAMP_W9) + {4'h0, s};
    endfunction

    // ------------------------------------------------------------
    // bus and register state
    // ------------------------------------------------------------
    logic [6:0]  ctrl_r    [NCH];
    logic [6:0]  ctrl_nxt  [NCH];
    logic [6:0]  data_r    [NRAM_CH];
    logic [6:0]  data_nxt  [NRAM_CH];
    logic [6:0]  tpl_ram   [RAM_WORDS];
    logic [NCH-1:0][5:0] scale_nxt;
    logic [31:0] rdata_nxt;
    logic        wait_nxt;
    twr_bus_e    bus_r;
    twr_bus_e    bus_nxt;
    logic        ram_we;
    logic [8:0]  ram_wa;
    logic [6:0]  ram_wd;

    always_comb begin
        twr_dec_s   d;
        logic       user;
        logic [3:0] rch;
        d         = decode(avm_req_i.address);
        user      = pulse_template_select_i[d.ch][PULS_USER_BIT];
        rch       = d.ch[3:0] - 4'h1;
        scale_nxt = amplitude_factor_o;
        ctrl_nxt  = ctrl_r;
        data_nxt  = data_r;
        rdata_nxt = avm_readdata_o;
        wait_nxt  = 1'b1;
        bus_nxt   = bus_r;
        ram_we    = 1'b0;
        ram_wa    = 9'h000;
        ram_wd    = 7'h00;
        case (bus_r)
            BUS_IDLE: begin
                if (avm_req_i.read || avm_req_i.write) begin
                    bus_nxt   = BUS_ACK;
                    wait_nxt  = 1'b0;
                    rdata_nxt = 32'h0000_0000;   // unmapped reads give zero
                    if (avm_req_i.read) begin
                        case (d.kind)
                            REG_SCALE: rdata_nxt = {26'h0, amplitude_factor_o[d.ch]};
                            REG_CTRL:  rdata_nxt = {25'h0, ctrl_r[d.ch]};
                            REG_DATA:  rdata_nxt = {25'h0, data_r[rch]};
                            default:   rdata_nxt = 32'h0000_0000;
                        endcase
                    end else if (avm_req_i.byteenable[0]) begin
                        case (d.kind)
                            REG_SCALE: begin
                                scale_nxt[d.ch] = avm_req_i.writedata[5:0];
                            end
                            REG_CTRL: begin
                                ctrl_nxt[d.ch] = avm_req_i.writedata[6:0];
                                // a read is launched by the control write itself
                                if (d.ch != 5'h00 && user
                                    && avm_req_i.writedata[CTRL_EN_BIT]
                                    && avm_req_i.writedata[CTRL_DIR_BIT]) begin
                                    data_nxt[rch] =
                                        tpl_ram[ram_index(rch, avm_req_i.writedata[4:0])];
                                end
                            end
                            REG_DATA: begin
                                data_nxt[rch] = avm_req_i.writedata[6:0];
                                if (user && ctrl_r[d.ch][CTRL_EN_BIT]
                                    && !ctrl_r[d.ch][CTRL_DIR_BIT]) begin
                                    ram_we = 1'b1;
                                    ram_wa = ram_index(rch, ctrl_r[d.ch][4:0]);
                                    ram_wd = avm_req_i.writedata[6:0];
                                end
                            end
                            default: begin
                                ram_we = 1'b0;
                            end
                        endcase
                    end
                end
            end
            BUS_ACK: begin
                bus_nxt = BUS_IDLE;
            end
            default: begin
                bus_nxt = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_r              <= BUS_IDLE;
            avm_waitrequest_o  <= 1'b1;
            avm_readdata_o     <= 32'h0000_0000;
            amplitude_factor_o <= {NCH{SCALE_RST}};
            for (int i = 0; i < NCH; i++) begin
                ctrl_r[i] <= CTRL_RST;
            end
            for (int i = 0; i < NRAM_CH; i++) begin
                data_r[i] <= DATA_RST;
            end
        end else begin
            bus_r              <= bus_nxt;
            avm_waitrequest_o  <= wait_nxt;
            avm_readdata_o     <= rdata_nxt;
            amplitude_factor_o <= scale_nxt;
            ctrl_r             <= ctrl_nxt;
            data_r             <= data_nxt;
        end
    end

    // ------------------------------------------------------------
    // template ram
    // ------------------------------------------------------------
    // no reset on the array: contents are undefined until software loads them
    logic [6:0] tpl_rd_nxt;

    always_comb begin
        tpl_rd_nxt = tpl_ram[ram_index(tpl_rd_ch_i, tpl_rd_idx_i)];
    end

    always_ff @(posedge mclk_i) begin
        if (ram_we) begin
            tpl_ram[ram_wa] <= ram_wd;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tpl_rd_data_o <= 7'h00;
        end else begin
            tpl_rd_data_o <= tpl_rd_nxt;
        end
    end

    // ------------------------------------------------------------
    // amplitude deviation per channel
    // ------------------------------------------------------------
    logic [NCH-1:0][7:0] pct_nxt;

    for (genvar g = 0; g < NCH; g++) begin : g_pct
        always_comb begin
            int diff;
            int pct;
            diff = 0;
            pct  = 0;
            if (e1_mode_i[g]) begin
                diff = int'(amplitude_factor_o[g]) - int'(SCALE_NOM_E1);
                pct  = diff * STEP_E1;
                if (pct > PCT_MAX_E1) pct = PCT_MAX_E1;
            end else begin
                diff = int'(amplitude_factor_o[g]) - int'(SCALE_NOM_T1);
                pct  = diff * STEP_T1;
                if (pct > PCT_MAX_T1) pct = PCT_MAX_T1;
            end
            if (pct < PCT_MIN) pct = PCT_MIN;
            pct_nxt[g] = pct[7:0];
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            amplitude_pct_o <= '0;
        end else begin
            amplitude_pct_o <= pct_nxt;
        end
    end

endmodule
`default_nettype wire

// ==== test/twr_regs_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module twr_regs_properties
    import twr_pkg::*;
(
    // bus
    input wire logic                mclk_i,
    input wire logic                rstn_i,
    input wire twr_avmm_req_s       avm_req_i,
    input wire logic [31:0]         avm_readdata_o,
    input wire logic                avm_waitrequest_o,
    // channel side
    input wire logic [NCH-1:0][3:0] pulse_template_select_i,
    input wire logic [NCH-1:0]      e1_mode_i,
    input wire logic [3:0]          tpl_rd_ch_i,
    input wire logic [4:0]          tpl_rd_idx_i,
    input wire logic [6:0]          tpl_rd_data_o,
    input wire logic [NCH-1:0][5:0] amplitude_factor_o,
    input wire logic [NCH-1:0][7:0] amplitude_pct_o
);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    wire logic tk;
    wire logic tw;
    assign tk = (avm_req_i.read | avm_req_i.write) & avm_waitrequest_o;
    assign tw = tk & avm_req_i.write & avm_req_i.byteenable[0];
    // the clamp keeps the +20 ceiling of t1 apart from the +100 of e1
    function automatic int pct(input logic [5:0] s, input logic e);
        int v;
        v = e ? (int'(s) - 33) * 3 : (int'(s) - 54) * 2;
        if (v < -100) v = -100;
        if (!e && v > 20) v = 20;
        return v;
    endfunction
    AST_ACK: assert property (tk |=> !avm_waitrequest_o) else $error("no ack");
    AST_ONE: assert property (!avm_waitrequest_o |=> avm_waitrequest_o) else $error("long ack");
    AST_RST: assert property ($rose(rstn_i) |-> amplitude_factor_o[1] == SCALE_RST)
        else $error("scale reset");
    AST_T1: assert property (!e1_mode_i[1] |=>
        $signed(amplitude_pct_o[1]) == pct($past(amplitude_factor_o[1]), 1'b0)) else $error("t1 pct");
    AST_E1: assert property (e1_mode_i[1] |=>
        $signed(amplitude_pct_o[1]) == pct($past(amplitude_factor_o[1]), 1'b1)) else $error("e1 pct");
    AST_RSV: assert property (!avm_waitrequest_o |-> avm_readdata_o[31:7] == '0)
        else $error("reserved bits");
    AST_SCL: assert property (tw && avm_req_i.address == OFS_SCALE |=>
        amplitude_factor_o[1] == $past(avm_req_i.writedata[5:0])) else $error("scale write");
    AST_CH0: assert property (tw && avm_req_i.address == OFS_CH0_SCALE |=>
        amplitude_factor_o[0] == $past(avm_req_i.writedata[5:0])) else $error("ch0 write");
    cover property (tw);
    cover property (tk && avm_req_i.read);
    cover property (e1_mode_i[1] && tw);
endmodule
bind twr_regs twr_regs_properties u_props (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .avm_req_i(avm_req_i), .avm_readdata_o(avm_readdata_o), .avm_waitrequest_o(avm_waitrequest_o),
    .pulse_template_select_i(pulse_template_select_i), .e1_mode_i(e1_mode_i),
    .tpl_rd_ch_i(tpl_rd_ch_i), .tpl_rd_idx_i(tpl_rd_idx_i), .tpl_rd_data_o(tpl_rd_data_o),
    .amplitude_factor_o(amplitude_factor_o), .amplitude_pct_o(amplitude_pct_o));
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench
    import twr_pkg::*;
;
    // ----------------------------------------
    // stimulus and checks
    // ----------------------------------------
    logic                mclk_i = 1'b0;
    logic                rstn_i = 1'b0;
    twr_avmm_req_s       req = '0;
    logic [31:0]         rdata;
    logic                wreq;
    logic [NCH-1:0][3:0] psel = '0;
    logic [NCH-1:0]      e1m = '0;
    logic [3:0]          rch = '0;
    logic [4:0]          ridx = '0;
    logic [6:0]          tdat;
    logic [NCH-1:0][5:0] fac;
    logic [NCH-1:0][7:0] pct;
    logic [31:0]         q;
    int                  err_total = 0;
    int                  samples_checked = 0;
    twr_regs DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .avm_req_i(req), .avm_readdata_o(rdata),
        .avm_waitrequest_o(wreq), .pulse_template_select_i(psel), .e1_mode_i(e1m),
        .tpl_rd_ch_i(rch), .tpl_rd_idx_i(ridx), .tpl_rd_data_o(tdat),
        .amplitude_factor_o(fac), .amplitude_pct_o(pct));
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    task automatic close_out;
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // one idle edge after each access so the request never changes twice in a step
    task automatic bus(input logic w, input logic [10:0] a, input logic [31:0] d, input logic [3:0] b);
        int n = 0;
        req <= twr_avmm_req_s'{read: !w, write: w, address: a, writedata: d, byteenable: b};
        do begin
            @(posedge mclk_i);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        q = rdata;
        if (wreq !== 1'b0) begin
            chk({31'h0, wreq}, 32'h0, "bus hang");
            close_out();
        end
        req <= '0;
        @(posedge mclk_i);
    endtask
    task automatic wr(input logic [10:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rd(input logic [10:0] a, input logic [31:0] e, input string m);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(q, e, m);
    endtask
    task automatic tpl(input logic [3:0] c, input logic [4:0] i, input logic [6:0] e);
        rch <= c;
        ridx <= i;
        repeat (2) @(posedge mclk_i);
        chk({25'h0, tdat}, {25'h0, e}, "template");
    endtask
    function automatic logic [7:0] pexp(input int s, input logic e);
        int v = e ? (s - 33) * 3 : (s - 54) * 2;
        if (v < -100) v = -100;
        if (!e && v > 20) v = 20;
        return v[7:0];
    endfunction
    task automatic t_rst;
        rd(11'h007, 32'h36, "scale rst");
        rd(11'h7C7, 32'h36, "ch0 rst");
        rd(11'h008, 32'h00, "ctrl rst");
        rd(11'h009, 32'h00, "data rst");
        $display("t_rst done");
    endtask
    task automatic t_scale;
        logic [5:0] sv [6] = '{6'h36, 6'h3F, 6'h00, 6'h21, 6'h3F, 6'h00};
        wr(11'h007, 32'hFF);
        rd(11'h007, 32'h3F, "scale rsv");
        bus(1'b1, 11'h007, 32'h10, 4'hE);
        rd(11'h007, 32'h3F, "lane off");
        wr(11'h7C7, 32'h21);
        rd(11'h7C7, 32'h21, "ch0 scale");
        wr(11'h3C7, 32'h15);
        rd(11'h3C7, 32'h15, "ch16 scale");
        for (int i = 0; i < 6; i++) begin
            e1m[1] <= (i >= 3);
            wr(11'h007, {26'h0, sv[i]});
            chk({24'h0, pct[1]}, {24'h0, pexp(sv[i], i >= 3)}, "pct");
        end
        $display("t_scale done");
    endtask
    task automatic t_ram;
        psel[3] <= 4'h8;
        wr(11'h088, 32'h45);
        wr(11'h089, 32'h5A);
        wr(11'h088, 32'h5F);
        wr(11'h089, 32'h33);
        tpl(4'h2, 5'h05, 7'h5A);
        tpl(4'h2, 5'h13, 7'h33);
        tpl(4'h2, 5'h19, 7'h33);
        rd(11'h088, 32'h5F, "ctrl");
        wr(11'h088, 32'h65);
        rd(11'h089, 32'h5A, "ram read");
        rd(11'h088, 32'h65, "dir");
        psel[3] <= 4'h7;
        wr(11'h088, 32'h45);
        wr(11'h089, 32'h7F);
        tpl(4'h2, 5'h05, 7'h5A);
        psel[3] <= 4'hF;
        wr(11'h089, 32'h81);
        tpl(4'h2, 5'h05, 7'h01);
        wr(11'h088, 32'h46);
        rd(11'h089, 32'h01, "data hold");
        $display("t_ram done");
    endtask
    task automatic t_unm;
        wr(11'h00A, 32'hFF);
        rd(11'h00A, 32'h00, "unmapped");
        rd(11'h7C9, 32'h00, "no ch0 data");
        wr(11'h7C8, 32'hE5);
        rd(11'h7C8, 32'h65, "ch0 ctrl");
        rd(11'h089, 32'h01, "ch0 ctrl no ram");
        $display("t_unm done");
    endtask
    initial begin
        repeat (2) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        t_rst();
        t_scale();
        t_ram();
        t_unm();
        close_out();
    end
endmodule
`default_nettype wire
